// *** inc/cem_cfg.svh ***
// register offsets, field positions, reset values and limits of the can error/timing/mailbox slice
`ifndef CEM_CFG_SVH
`define CEM_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on apb)
// ----------------------------------------------------------------
`define CEM_OFF_TX_STATUS 12'h008
`define CEM_OFF_RX_CTRL 12'h00C
`define CEM_OFF_ERR_STATUS 12'h018
`define CEM_OFF_BIT_TIMING 12'h01C
`define CEM_TX_ID_REGION 6'h06
`define CEM_RX_ID_REGION 6'h07
`define CEM_ADDR_W 12

// ----------------------------------------------------------------
// error status fields
// ----------------------------------------------------------------
`define CEM_ES_ETC_MSB 6
`define CEM_ES_ETC_LSB 4

// ----------------------------------------------------------------
// bit timing fields
// ----------------------------------------------------------------
`define CEM_BT_LSTN_BIT 31
`define CEM_BT_LOOP_BIT 30
`define CEM_BT_SJW_MSB 25
`define CEM_BT_SJW_LSB 24
`define CEM_BT_SEG2_MSB 22
`define CEM_BT_SEG2_LSB 20
`define CEM_BT_SEG1_MSB 19
`define CEM_BT_SEG1_LSB 16
`define CEM_BT_PRESC_MSB 11
`define CEM_BT_RESET 32'h0123_0000
`define CEM_BT_WMASK 32'hC37F_0FFF

// ----------------------------------------------------------------
// fault confinement limits
// ----------------------------------------------------------------
`define CEM_WARN_LIMIT 9'h060
`define CEM_PASSIVE_LIMIT 9'h07F
`define CEM_BUSOFF_LIMIT 9'h0FF
`define CEM_TX_ERR_STEP 9'h008
`define CEM_RX_ERR_HEAVY 9'h008
`define CEM_RXE_RELOAD 8'h78

// ----------------------------------------------------------------
// mailbox counts
// ----------------------------------------------------------------
`define CEM_TX_BOXES 3
`define CEM_RX_BOXES 2
`define CEM_FIFO_DEPTH 2'h3
`define CEM_RX_REL_STRIDE 8

`endif

// *** inc/cem_pkg.sv ***
// types shared by the can error/timing/mailbox slice
package cem_pkg;

  // ----------------------------------------------------------------
  // error type codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CEM_ERR_NONE = 3'h0,
    CEM_ERR_STUFF = 3'h1,
    CEM_ERR_FORM = 3'h2,
    CEM_ERR_ACK = 3'h3,
    CEM_ERR_RECESSIVE = 3'h4,
    CEM_ERR_DOMINANT = 3'h5,
    CEM_ERR_CRC = 3'h6,
    CEM_ERR_SOFTWARE = 3'h7
  } cem_err_t;

  // ----------------------------------------------------------------
  // bit time segments, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CEM_BT_SYNC = 3'b001,
    CEM_BT_SEG1 = 3'b010,
    CEM_BT_SEG2 = 3'b100
  } cem_bt_state_t;

  // ----------------------------------------------------------------
  // protocol engine events and receive pushes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic err_valid;
    cem_err_t err_code;
    logic err_as_tx;
    logic err_rx_heavy;
    logic tx_ok;
    logic rx_ok;
    logic [1:0] tx_box;
  } cem_evt_t;

  typedef struct packed {
    logic valid;
    logic fifo;
    logic [31:0] id_word;
  } cem_rx_push_t;

endpackage

// *** hdl/cem_top.sv ***
// can error counters, bit timing, transmit identifiers and receive fifos behind apb
//
// Overview of operation
// - receive error counter in status bits 31:24
// - transmit error counter in status bits 23:16
// - error type codes 0..6, 7 for software
// - hardware loads error type on detected error
// - successful frame clears error type to zero
// - software code 7 holds until hardware overwrites
// - transmit count above 255 enters bus-off
// - either counter above 127 flags error passive
// - either counter 96 or more flags warning
// - timing bit 31 selects listen-only operation
// - timing bit 30 selects loop-back operation
// - resync width limits adjustment to value+1
// - segment two lasts value+1 quanta
// - segment one lasts value+1 quanta
// - quantum lasts prescaler+1 clock periods
// - three transmit and two receive mailboxes
// - receive fifo three deep, oldest visible
// - receive read-only, transmit writable when empty
// - identifier ignores writes while send pending
// - identifier bits 31:21 and 20:3 layout
// - bit 2 id format, bit 1 frame kind
// - write one requests send, hardware clears
`include "cem_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cem_top (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can line
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  // protocol engine side
  input wire cem_pkg::cem_evt_t evt,
  input wire cem_pkg::cem_rx_push_t rx_push,
  input wire logic tx_bit,
  output logic [2:0] tx_pending,
  output logic sample_pulse,
  output logic sample_bit,
  output logic listen_only,
  output logic loop_back,
  output logic bus_off
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rx_meta_q, rx_pin_q, rx_prev_q, rx_prev_d, can_tx_q, can_tx_d, rx_line, fall;
  logic [31:0] prdata_q, prdata_d, rdata;
  logic pready_q, pready_d, pslverr_q, pslverr_d, hit, wr_fire;
  logic tx_hit, rx_hit, es_hit, bt_hit, rxc_hit;
  logic [1:0] mb_idx;
  logic [31:0] bt_q, bt_d;
  logic [7:0] rxe_q, rxe_d;
  logic [8:0] txe_q, txe_d, rxe_sum;
  logic [2:0] etc_q, etc_d;
  logic bof_q, bof_d, ep_q, ep_d, ew_q, ew_d;
  logic [30:0] tx_id_q [`CEM_TX_BOXES];
  logic pend_q [`CEM_TX_BOXES];
  logic [31:0] rx_head [`CEM_RX_BOXES];
  logic [1:0] rx_cnt [`CEM_RX_BOXES];
  logic [11:0] tq_cnt_q, tq_cnt_d;
  logic tq_tick;
  cem_pkg::cem_bt_state_t bts_q, bts_d;
  logic [4:0] seg_cnt_q, seg_cnt_d, adj_q, adj_d, cnt_n, seg1_len, seg2_len, sjw_len, rem, lim;
  logic done_q, done_d, edge_q, edge_d, ev;
  logic smp_pulse_q, smp_pulse_d, smp_bit_q, smp_bit_d;

  // ----------------------------------------------------------------
  // line synchroniser and tx drive
  // ----------------------------------------------------------------
  always_comb begin
    can_tx_d = bt_q[`CEM_BT_LSTN_BIT] ? 1'b1 : tx_bit;
    rx_line = bt_q[`CEM_BT_LOOP_BIT] ? can_tx_q : rx_pin_q;
    rx_prev_d = rx_line;
    fall = rx_prev_q & ~rx_line;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_pin_q <= 1'b1;
      rx_prev_q <= 1'b1;
      can_tx_q <= 1'b1;
    end else if (ce) begin
      rx_meta_q <= can_rx_pin;
      rx_pin_q <= rx_meta_q;
      rx_prev_q <= rx_prev_d;
      can_tx_q <= can_tx_d;
    end
  end

  // ----------------------------------------------------------------
  // apb decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    mb_idx = paddr[5:4];
    tx_hit = (paddr[11:6] == `CEM_TX_ID_REGION) && (paddr[3:0] == 4'h0) && (mb_idx < 2'h3);
    rx_hit = (paddr[11:6] == `CEM_RX_ID_REGION) && (paddr[3:0] == 4'h0) && (mb_idx < 2'h2);
    es_hit = paddr == `CEM_OFF_ERR_STATUS;
    bt_hit = paddr == `CEM_OFF_BIT_TIMING;
    rxc_hit = paddr == `CEM_OFF_RX_CTRL;
    hit = tx_hit | rx_hit | es_hit | bt_hit | rxc_hit | (paddr == `CEM_OFF_TX_STATUS);
    rdata = 32'h0000_0000;
    if (es_hit) begin
      rdata[31:24] = rxe_q;
      rdata[23:16] = txe_q[8] ? 8'hFF : txe_q[7:0];
      rdata[6:4] = etc_q;
      rdata[2:0] = {bof_q, ep_q, ew_q};
    end else if (bt_hit) begin
      rdata = bt_q;
    end else if (tx_hit) begin
      rdata = {tx_id_q[mb_idx], pend_q[mb_idx]};
    end else if (rx_hit) begin
      rdata = rx_head[mb_idx[0]];
    end else if (rxc_hit) begin
      rdata[1:0] = rx_cnt[0];
      rdata[9:8] = rx_cnt[1];
    end else if (paddr == `CEM_OFF_TX_STATUS) begin
      rdata[2:0] = {~pend_q[2], ~pend_q[1], ~pend_q[0]};
    end
    // one wait state: answer on the second access cycle
    pready_d = psel & penable & ~pready_q;
    pslverr_d = psel & penable & ~pready_q & ~hit;
    prdata_d = (psel & penable & ~pready_q & ~pwrite) ? rdata : prdata_q;
    wr_fire = psel & penable & pready_q & pwrite;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // bit timing register
  // ----------------------------------------------------------------
  always_comb begin
    bt_d = bt_q;
    if (wr_fire && bt_hit) begin
      bt_d = pwdata & `CEM_BT_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bt_q <= `CEM_BT_RESET;
    end else if (ce) begin
      bt_q <= bt_d;
    end
  end

  // ----------------------------------------------------------------
  // fault confinement
  // ----------------------------------------------------------------
  always_comb begin
    rxe_d = rxe_q;
    txe_d = txe_q;
    etc_d = etc_q;
    bof_d = bof_q;
    rxe_sum = {1'b0, rxe_q} + (evt.err_rx_heavy ? `CEM_RX_ERR_HEAVY : 9'h001);
    if (wr_fire && es_hit) begin
      etc_d = pwdata[`CEM_ES_ETC_MSB:`CEM_ES_ETC_LSB];
    end
    // counters freeze once bus-off; only reset brings the node back
    if (!bof_q) begin
      if (evt.err_valid) begin
        etc_d = evt.err_code;
        if (evt.err_as_tx) begin
          txe_d = txe_q + `CEM_TX_ERR_STEP;
        end else begin
          rxe_d = rxe_sum[8] ? 8'hFF : rxe_sum[7:0];
        end
      end else if (evt.tx_ok || evt.rx_ok) begin
        etc_d = cem_pkg::CEM_ERR_NONE;
        if (evt.tx_ok && (txe_q != 9'h000)) begin
          txe_d = txe_q - 9'h001;
        end
        if (evt.rx_ok) begin
          if ({1'b0, rxe_q} > `CEM_PASSIVE_LIMIT) begin
            rxe_d = `CEM_RXE_RELOAD;
          end else if (rxe_q != 8'h00) begin
            rxe_d = rxe_q - 8'h01;
          end
        end
      end
    end
    if (txe_d > `CEM_BUSOFF_LIMIT) begin
      bof_d = 1'b1;
    end
    ep_d = ({1'b0, rxe_d} > `CEM_PASSIVE_LIMIT) || (txe_d > `CEM_PASSIVE_LIMIT);
    ew_d = ({1'b0, rxe_d} >= `CEM_WARN_LIMIT) || (txe_d >= `CEM_WARN_LIMIT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxe_q <= 8'h00;
      txe_q <= 9'h000;
      etc_q <= 3'h0;
      bof_q <= 1'b0;
      ep_q <= 1'b0;
      ew_q <= 1'b0;
    end else if (ce) begin
      rxe_q <= rxe_d;
      txe_q <= txe_d;
      etc_q <= etc_d;
      bof_q <= bof_d;
      ep_q <= ep_d;
      ew_q <= ew_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit mailbox identifiers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `CEM_TX_BOXES; i++) begin : g_tx
    logic [30:0] id_d;
    logic pend_d;
    always_comb begin
      id_d = tx_id_q[i];
      pend_d = pend_q[i];
      if (evt.tx_ok && (evt.tx_box == 2'(i))) begin
        pend_d = 1'b0;
      end
      // a pending box cannot be written, so completion and request never meet
      if (wr_fire && tx_hit && (mb_idx == 2'(i)) && !pend_q[i]) begin
        id_d = pwdata[31:1];
        if (pwdata[0]) begin
          pend_d = 1'b1;
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_id_q[i] <= 31'h0000_0000;
        pend_q[i] <= 1'b0;
      end else if (ce) begin
        tx_id_q[i] <= id_d;
        pend_q[i] <= pend_d;
      end
    end
    assign tx_pending[i] = pend_q[i];
  end

  // ----------------------------------------------------------------
  // receive fifos
  // ----------------------------------------------------------------
  for (genvar j = 0; j < `CEM_RX_BOXES; j++) begin : g_rx
    logic [31:0] mem_q [3];
    logic [31:0] mem_d [3];
    logic [1:0] rd_q, rd_d, wr_q, wr_d, cnt_q, cnt_d;
    logic push, pop;
    always_comb begin
      // a full fifo drops the newest frame
      push = rx_push.valid && (rx_push.fifo == 1'(j)) && (cnt_q < `CEM_FIFO_DEPTH);
      pop = wr_fire && rxc_hit && pwdata[j * `CEM_RX_REL_STRIDE] && (cnt_q != 2'h0);
      mem_d = mem_q;
      rd_d = rd_q;
      wr_d = wr_q;
      cnt_d = cnt_q;
      if (push) begin
        mem_d[wr_q] = {rx_push.id_word[31:1], 1'b0};
        wr_d = (wr_q == 2'h2) ? 2'h0 : wr_q + 2'h1;
      end
      if (pop) begin
        rd_d = (rd_q == 2'h2) ? 2'h0 : rd_q + 2'h1;
      end
      if (push && !pop) begin
        cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_d = cnt_q - 2'h1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_q <= '{default: 32'h0000_0000};
        rd_q <= 2'h0;
        wr_q <= 2'h0;
        cnt_q <= 2'h0;
      end else if (ce) begin
        mem_q <= mem_d;
        rd_q <= rd_d;
        wr_q <= wr_d;
        cnt_q <= cnt_d;
      end
    end
    assign rx_head[j] = (cnt_q == 2'h0) ? 32'h0000_0000 : mem_q[rd_q];
    assign rx_cnt[j] = cnt_q;
  end

  // ----------------------------------------------------------------
  // bit timing engine
  // ----------------------------------------------------------------
  always_comb begin
    // >= so a smaller prescaler written mid-quantum cannot strand the counter
    tq_tick = tq_cnt_q >= bt_q[`CEM_BT_PRESC_MSB:0];
    tq_cnt_d = tq_tick ? 12'h000 : tq_cnt_q + 12'h001;
    sjw_len = {3'h0, bt_q[`CEM_BT_SJW_MSB:`CEM_BT_SJW_LSB]} + 5'h01;
    seg1_len = {1'b0, bt_q[`CEM_BT_SEG1_MSB:`CEM_BT_SEG1_LSB]} + 5'h01;
    seg2_len = {2'h0, bt_q[`CEM_BT_SEG2_MSB:`CEM_BT_SEG2_LSB]} + 5'h01;
    ev = edge_q | fall;
    edge_d = tq_tick ? fall : ev;
    bts_d = bts_q;
    seg_cnt_d = seg_cnt_q;
    adj_d = adj_q;
    done_d = done_q;
    smp_pulse_d = 1'b0;
    smp_bit_d = smp_bit_q;
    cnt_n = seg_cnt_q + 5'h01;
    rem = seg2_len - cnt_n;
    lim = 5'h00;
    if (tq_tick) begin
      case (bts_q)
        cem_pkg::CEM_BT_SYNC: begin
          bts_d = cem_pkg::CEM_BT_SEG1;
          seg_cnt_d = 5'h00;
          adj_d = 5'h00;
          done_d = 1'b0;
        end
        cem_pkg::CEM_BT_SEG1: begin
          // late edge: stretch segment one by the phase error, capped
          if (ev && !done_q) begin
            adj_d = (cnt_n > sjw_len) ? sjw_len : cnt_n;
            done_d = 1'b1;
          end
          lim = seg1_len + adj_d;
          if (cnt_n >= lim) begin
            bts_d = cem_pkg::CEM_BT_SEG2;
            seg_cnt_d = 5'h00;
            adj_d = 5'h00;
            smp_pulse_d = 1'b1;
            smp_bit_d = rx_line;
          end else begin
            seg_cnt_d = cnt_n;
          end
        end
        cem_pkg::CEM_BT_SEG2: begin
          // early edge: cut segment two, or restart the bit if the cut fits
          if (ev && !done_q) begin
            done_d = 1'b1;
            if (rem <= sjw_len) begin
              adj_d = 5'h1F;
            end else begin
              adj_d = sjw_len;
            end
          end
          lim = seg2_len - adj_d;
          if (adj_d == 5'h1F) begin
            bts_d = cem_pkg::CEM_BT_SEG1;
            seg_cnt_d = 5'h00;
            adj_d = 5'h00;
          end else if ((cnt_n >= lim) || (lim > seg2_len)) begin
            bts_d = cem_pkg::CEM_BT_SYNC;
            seg_cnt_d = 5'h00;
            adj_d = 5'h00;
          end else begin
            seg_cnt_d = cnt_n;
          end
        end
        default: begin
          bts_d = cem_pkg::CEM_BT_SYNC;
          seg_cnt_d = 5'h00;
          adj_d = 5'h00;
          done_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_cnt_q <= 12'h000;
      bts_q <= cem_pkg::CEM_BT_SYNC;
      seg_cnt_q <= 5'h00;
      adj_q <= 5'h00;
      done_q <= 1'b0;
      edge_q <= 1'b0;
      smp_pulse_q <= 1'b0;
      smp_bit_q <= 1'b1;
    end else if (ce) begin
      tq_cnt_q <= tq_cnt_d;
      bts_q <= bts_d;
      seg_cnt_q <= seg_cnt_d;
      adj_q <= adj_d;
      done_q <= done_d;
      edge_q <= edge_d;
      smp_pulse_q <= smp_pulse_d;
      smp_bit_q <= smp_bit_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign can_tx_pin = can_tx_q;
  assign sample_pulse = smp_pulse_q;
  assign sample_bit = smp_bit_q;
  assign listen_only = bt_q[`CEM_BT_LSTN_BIT];
  assign loop_back = bt_q[`CEM_BT_LOOP_BIT];
  assign bus_off = bof_q;

endmodule

`default_nettype wire

// *** tb/cem_top_asserts.sv ***
// concurrent checks on the ports of cem_top
`timescale 1ns/100ps
`default_nettype none
`include "cem_cfg.svh"

module cem_top_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // engine and line
  input wire cem_pkg::cem_evt_t evt,
  input wire logic tx_bit,
  input wire logic can_tx_pin,
  input wire logic [2:0] tx_pending,
  input wire logic sample_pulse,
  input wire logic sample_bit,
  input wire logic listen_only,
  input wire logic loop_back,
  input wire logic bus_off
);
  logic done;
  logic wr_bt;
  logic wr_req;
  assign done = psel & penable & pready;
  assign wr_bt = done & pwrite & (paddr == `CEM_OFF_BIT_TIMING);
  assign wr_req = done & pwrite & pwdata[0] & (paddr[11:6] == `CEM_TX_ID_REGION);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("no one-wait answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_tx_follows_bit: assert property ($past(presetn) && !listen_only && !$past(listen_only)
    |-> can_tx_pin == $past(tx_bit))
    else $error("tx pin not tx bit");
  a_listen_recessive: assert property (listen_only && $past(listen_only) |-> can_tx_pin)
    else $error("dominant in listen-only");
  a_mode_by_write: assert property ($changed({listen_only, loop_back}) |-> $past(wr_bt) || $past(wr_bt, 2))
    else $error("mode changed unwritten");
  a_pend_set: assert property (|(tx_pending & ~$past(tx_pending)) |-> $past(wr_req) || $past(wr_req, 2))
    else $error("request set unasked");
  a_pend_clear: assert property (|(~tx_pending & $past(tx_pending)) |-> $past(evt.tx_ok) || $past(evt.tx_ok, 2))
    else $error("request cleared early");
  a_busoff_hold: assert property (bus_off |=> bus_off)
    else $error("bus-off left before reset");
  a_busoff_cause: assert property ($rose(bus_off) |-> $past(evt.err_valid && evt.err_as_tx)
    || $past(evt.err_valid && evt.err_as_tx, 2))
    else $error("bus-off without transmit error");
  a_sample_hold: assert property ($changed(sample_bit) |-> sample_pulse)
    else $error("sample bit moved off sample");
  a_sample_single: assert property (sample_pulse |=> !sample_pulse)
    else $error("sample pulse too long");
endmodule
`default_nettype wire

// *** tb/cem_can_node.sv ***
// can node on the far side of the transceiver
`timescale 1ns/100ps
`default_nettype none

module cem_can_node (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line
  input wire logic tx_pin,
  output logic rx_pin,
  // frame control
  input wire logic send,
  input wire logic [7:0] frame,
  input wire logic [15:0] bit_len,
  input wire logic force_dom
);
  logic [7:0] sh_q;
  logic [3:0] left_q;
  logic [15:0] cnt_q;

  // wired-and bus; pull-up leaves it recessive when nobody drives
  assign rx_pin = tx_pin & ~force_dom & ((left_q == 4'h0) | sh_q[7]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 8'hFF;
      left_q <= 4'h0;
      cnt_q <= 16'h0000;
    end else if (send) begin
      sh_q <= frame;
      left_q <= 4'h8;
      cnt_q <= bit_len - 16'h0001;
    end else if (left_q != 4'h0) begin
      if (cnt_q == 16'h0000) begin
        sh_q <= {sh_q[6:0], 1'b1};
        left_q <= left_q - 4'h1;
        cnt_q <= bit_len - 16'h0001;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/cem_top_test.sv ***
// self-checking bench for cem_top
`timescale 1ns/100ps
`default_nettype none
`include "cem_cfg.svh"

module cem_top_test;
  logic pclk;
  logic presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tx_bit = 1'b1, send = 1'b0, force_dom = 1'b0, tx_rand = 1'b0, found;
  logic [11:0] paddr = 12'h000, ta;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
  cem_pkg::cem_evt_t evt = '0;
  cem_pkg::cem_rx_push_t rx_push = '0;
  logic pready, pslverr, can_rx_pin, can_tx_pin, sample_pulse, sample_bit, listen_only, loop_back, bus_off, err;
  logic [2:0] tx_pending;
  logic [15:0] seed_q = 16'h0016, tx_s_q = 16'h0016;
  logic [8:0] txe = 9'h000;
  logic [7:0] rxe = 8'h00, sh;
  logic [2:0] ecd = 3'h0;
  int miscompares = 0, comparisons = 0, n;
  logic [31:0] bt_tab [3] = '{32'h0123_0000, 32'h0115_0002, 32'h017F_0001};

  cem_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .evt(evt), .rx_push(rx_push), .tx_bit(tx_bit),
    .tx_pending(tx_pending), .sample_pulse(sample_pulse), .sample_bit(sample_bit),
    .listen_only(listen_only), .loop_back(loop_back), .bus_off(bus_off));
  cem_can_node node_u (.pclk(pclk), .presetn(presetn), .tx_pin(can_tx_pin), .rx_pin(can_rx_pin),
    .send(send), .frame(8'hA5), .bit_len(16'h0008), .force_dom(force_dom));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    tx_s_q <= lfsr(tx_s_q);
    if (tx_rand === 1'b1) tx_bit <= tx_s_q[3];
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] blen(input logic [31:0] t);
    return (32'(t[11:0]) + 32'h1) * (32'(t[19:16]) + 32'(t[22:20]) + 32'h3);
  endfunction
  function automatic logic [31:0] status_exp();
    return {rxe, (txe > 9'h0FF) ? 8'hFF : txe[7:0], 9'h000, ecd, 1'b0, txe > 9'h0FF,
      (rxe > 8'h7F) || (txe > 9'h07F), (rxe >= 8'h60) || (txe >= 9'h060)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic period(output int c);
    @(negedge pclk);
    while (sample_pulse !== 1'b1) @(negedge pclk);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (sample_pulse !== 1'b1);
  endtask
  // kinds: 0-3 tx err, 4 rx err, 5 heavy rx, 6 sent, 7 received
  task automatic ev(input logic [2:0] k, input logic [2:0] c, input logic [1:0] b);
    @(posedge pclk);
    evt <= '{err_valid: k < 3'h6, err_code: cem_pkg::cem_err_t'(c), err_as_tx: k < 3'h4,
      err_rx_heavy: k == 3'h5, tx_ok: k == 3'h6, rx_ok: k == 3'h7, tx_box: b};
    @(posedge pclk);
    evt <= '0;
    if (txe > 9'h0FF) return;
    ecd = (k < 3'h6) ? c : 3'h0;
    case (k)
      3'h4: rxe = (rxe == 8'hFF) ? rxe : rxe + 8'h01;
      3'h5: rxe = (rxe > 8'hF7) ? 8'hFF : rxe + 8'h08;
      3'h6: txe = (txe == 9'h000) ? txe : txe - 9'h001;
      3'h7: rxe = (rxe > 8'h7F) ? 8'h78 : (rxe == 8'h00) ? rxe : rxe - 8'h01;
      default: txe = txe + 9'h008;
    endcase
  endtask
  task automatic push(input logic f, input logic [31:0] w);
    @(posedge pclk);
    rx_push <= '{valid: 1'b1, fifo: f, id_word: w};
    @(posedge pclk);
    rx_push <= '0;
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`CEM_OFF_BIT_TIMING, 32'h0123_0000);
    rdchk(`CEM_OFF_ERR_STATUS, 32'h0000_0000);
    rdchk(`CEM_OFF_TX_STATUS, 32'h0000_0007);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk(32'(err), 32'h1);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      seed_q = lfsr(seed_q);
      v = {seed_q, lfsr(seed_q)};
      apb(1'b1, `CEM_OFF_BIT_TIMING, v);
      rdchk(`CEM_OFF_BIT_TIMING, v & `CEM_BT_WMASK);
      chk({30'h0, listen_only, loop_back}, {30'h0, v[31:30]});
    end
    // skip the bit cut short by the write
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `CEM_OFF_BIT_TIMING, bt_tab[i]);
      period(n);
      period(n);
      chk(32'(n), blen(bt_tab[i]));
    end
    $display("test bit timing done");
    apb(1'b1, `CEM_OFF_BIT_TIMING, 32'h0123_0000);
    @(posedge pclk);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    sh = 8'hFF;
    found = 1'b0;
    for (int i = 0; i < 140; i++) begin
      @(negedge pclk);
      if (sample_pulse === 1'b1) sh = {sh[6:0], sample_bit};
      if (sh === 8'hA5) found = 1'b1;
    end
    chk(32'(found), 32'h1);
    apb(1'b1, `CEM_OFF_BIT_TIMING, 32'h4123_0000);
    force_dom <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(sample_bit), 32'h1);
    apb(1'b1, `CEM_OFF_BIT_TIMING, 32'h8123_0000);
    tx_bit <= 1'b0;
    repeat (30) @(posedge pclk);
    chk({31'h0, can_tx_pin}, 32'h1);
    chk(32'(sample_bit), 32'h0);
    apb(1'b1, `CEM_OFF_BIT_TIMING, 32'h0123_0000);
    tx_bit <= 1'b1;
    force_dom <= 1'b0;
    $display("test line modes done");
    for (int b = 0; b < 3; b++) begin
      seed_q = lfsr(seed_q);
      v = {seed_q, lfsr(seed_q)} | 32'h1;
      ta = 12'h180 + 12'(16 * b);
      apb(1'b1, ta, v);
      rdchk(ta, v);
      chk(32'(tx_pending), 32'h1 << b);
      apb(1'b1, ta, ~v);
      rdchk(ta, v);
      rdchk(`CEM_OFF_TX_STATUS, 32'h7 & ~(32'h1 << b));
      ev(3'h6, 3'h0, 2'(b));
      rdchk(ta, v & ~32'h1);
      apb(1'b1, ta, ~v & ~32'h1);
      rdchk(ta, ~v & ~32'h1);
      chk(32'(tx_pending), 32'h0);
    end
    $display("test transmit mailboxes done");
    for (int i = 0; i < 4; i++) push(1'b0, 32'hC0DE_0001 + 32'(i << 4));
    rdchk(`CEM_OFF_RX_CTRL, 32'h0000_0003);
    rdchk(12'h1C0, 32'hC0DE_0000);
    apb(1'b1, 12'h1C0, 32'h0000_0000);
    rdchk(12'h1C0, 32'hC0DE_0000);
    apb(1'b1, `CEM_OFF_RX_CTRL, 32'h0000_0001);
    rdchk(12'h1C0, 32'hC0DE_0010);
    push(1'b1, 32'h1234_5677);
    rdchk(12'h1D0, 32'h1234_5676);
    rdchk(`CEM_OFF_RX_CTRL, 32'h0000_0102);
    $display("test receive fifos done");
    apb(1'b1, `CEM_OFF_ERR_STATUS, 32'hFFFF_FFFF);
    ecd = 3'h7;
    rdchk(`CEM_OFF_ERR_STATUS, status_exp());
    tx_rand = 1'b1;
    for (int i = 0; i < 100; i++) begin
      seed_q = lfsr(seed_q);
      ev(seed_q[2:0], 3'h1 + 3'(seed_q[7:4] % 6), 2'h0);
      rdchk(`CEM_OFF_ERR_STATUS, status_exp());
      chk(32'(bus_off), 32'(txe > 9'h0FF));
    end
    tx_rand = 1'b0;
    $display("test fault confinement done");
    conclude();
  end
endmodule

bind cem_top cem_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .evt(evt),
  .tx_bit(tx_bit), .can_tx_pin(can_tx_pin), .tx_pending(tx_pending), .sample_pulse(sample_pulse),
  .sample_bit(sample_bit), .listen_only(listen_only), .loop_back(loop_back), .bus_off(bus_off));
`default_nettype wire
